// ### hdl/cpurf_core.v
// cpu register file with two banks, stack pointers and flag word
// Overview of operation
// - thirteen core registers visible, banked group counted once
// - two full copies of data, address and frame base registers
// - data registers 16 bits; first two also as upper/lower bytes
// - third pairs with first, fourth with second, upper half high
// - two 16-bit address registers, also one 32-bit pair, second high
// - frame base is a 16-bit register
// - vector table base is a 20-bit register
// - program counter is 20 bits, next instruction address
// - user and interrupt stack pointers, one active at a time
// - stack select 0 picks interrupt pointer, 1 picks user pointer
// - stack select cleared on hardware interrupt or soft vector 0..31
// - static base is a 16-bit register
// - flag word is 11 bits showing processor state
// - carry takes carry, borrow or shifted-out bit from the alu
// - zero flag set when arithmetic result is zero
// - sign flag set when arithmetic result is negative
// - bank select 0 picks bank zero, 1 picks bank one
// - overflow flag set on overflow, else cleared
// - interrupt enable gates maskable interrupts; cleared on acceptance
// - 3-bit priority level; request enabled only if above it
// - reserved flag bits read undefined, written as zero
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "cpurf_regs.vh"
module cpurf_core (
    input wire clk,
    input wire rst,
    input wire [4:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output reg [31:0] regRdData,
    input wire aluFlagStb,
    input wire aluCarry,
    input wire aluZero,
    input wire aluSign,
    input wire aluOverflow,
    input wire hwIntAccept,
    input wire swIntExec,
    input wire [5:0] swIntNum,
    input wire intReqValid,
    input wire [2:0] intReqLevel,
    output reg intEnabled,
    output reg userStackSel,
    output reg bankSel,
    output reg [15:0] activeStack,
    output reg [19:0] progCounter
);
    // banked group: index 0..6 inside a bank, bank adds 7
    // seven banked plus six unbanked registers make the visible set
    reg [15:0] bankRegQ [0:13];
    reg [19:0] vtbQ, pcQ;
    reg [15:0] uspQ, ispQ, sbQ;
    reg [15:0] flgQ;
    reg [15:0] flgD;
    wire bankB = flgQ[`CPURF_FLG_B];
    integer i;

    function [3:0] bidx;
        input b;
        input [2:0] r;
        begin
            bidx = b ? {1'b0, r} + 4'h7 : {1'b0, r};
        end
    endfunction

    // bank chosen from current flag, other bank untouched
    wire [15:0] r0 = bankRegQ[bidx(bankB, 3'h0)];
    wire [15:0] r1 = bankRegQ[bidx(bankB, 3'h1)];
    wire [15:0] r2 = bankRegQ[bidx(bankB, 3'h2)];
    wire [15:0] r3 = bankRegQ[bidx(bankB, 3'h3)];
    wire [15:0] a0 = bankRegQ[bidx(bankB, 3'h4)];
    wire [15:0] a1 = bankRegQ[bidx(bankB, 3'h5)];
    wire [15:0] fb = bankRegQ[bidx(bankB, 3'h6)];
    wire [15:0] sp = flgQ[`CPURF_FLG_U] ? uspQ : ispQ;

    // acceptance of any interrupt
    wire intTaken = hwIntAccept | swIntExec;
    wire swUser = swIntExec & (swIntNum <= `CPURF_SWI_USER_MAX);

    // flag word: software write, then alu update, then interrupt
    // acceptance, so hardware events always win the same cycle
    always @* begin
        flgD = flgQ;
        if (regWrStb && regAddr == `CPURF_IDX_FLG) begin
            // reserved bits never stored
            flgD = regWrData[15:0] & `CPURF_FLG_WMASK;
        end
        if (aluFlagStb) begin
            flgD[`CPURF_FLG_C] = aluCarry;
            flgD[`CPURF_FLG_Z] = aluZero;
            flgD[`CPURF_FLG_S] = aluSign;
            flgD[`CPURF_FLG_O] = aluOverflow;
        end
        if (intTaken) begin
            flgD[`CPURF_FLG_I] = 1'b0;
        end
        if (hwIntAccept || swUser) begin
            flgD[`CPURF_FLG_U] = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < 14; i = i + 1) begin
                bankRegQ[i] <= `CPURF_RST16;
            end
            vtbQ <= `CPURF_RST20;
            pcQ <= `CPURF_RST20;
            uspQ <= `CPURF_RST16;
            ispQ <= `CPURF_RST16;
            sbQ <= `CPURF_RST16;
            flgQ <= `CPURF_RST16;
        end else begin
            if (regWrStb) begin
                if (regAddr == `CPURF_IDX_R0) begin
                    bankRegQ[bidx(bankB, 3'h0)] <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_R1) begin
                    bankRegQ[bidx(bankB, 3'h1)] <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_R2) begin
                    bankRegQ[bidx(bankB, 3'h2)] <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_R3) begin
                    bankRegQ[bidx(bankB, 3'h3)] <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_A0) begin
                    bankRegQ[bidx(bankB, 3'h4)] <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_A1) begin
                    bankRegQ[bidx(bankB, 3'h5)] <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_FB) begin
                    bankRegQ[bidx(bankB, 3'h6)] <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_R0U) begin
                    bankRegQ[bidx(bankB, 3'h0)] <= {regWrData[7:0], r0[7:0]};
                end else if (regAddr == `CPURF_IDX_R0L) begin
                    bankRegQ[bidx(bankB, 3'h0)] <= {r0[15:8], regWrData[7:0]};
                end else if (regAddr == `CPURF_IDX_R1U) begin
                    bankRegQ[bidx(bankB, 3'h1)] <= {regWrData[7:0], r1[7:0]};
                end else if (regAddr == `CPURF_IDX_R1L) begin
                    bankRegQ[bidx(bankB, 3'h1)] <= {r1[15:8], regWrData[7:0]};
                end else if (regAddr == `CPURF_IDX_LDL) begin
                    bankRegQ[bidx(bankB, 3'h0)] <= regWrData[15:0];
                    bankRegQ[bidx(bankB, 3'h2)] <= regWrData[31:16];
                end else if (regAddr == `CPURF_IDX_LDH) begin
                    bankRegQ[bidx(bankB, 3'h1)] <= regWrData[15:0];
                    bankRegQ[bidx(bankB, 3'h3)] <= regWrData[31:16];
                end else if (regAddr == `CPURF_IDX_LAP) begin
                    bankRegQ[bidx(bankB, 3'h4)] <= regWrData[15:0];
                    bankRegQ[bidx(bankB, 3'h5)] <= regWrData[31:16];
                end else if (regAddr == `CPURF_IDX_VTB) begin
                    vtbQ <= regWrData[19:0];
                end else if (regAddr == `CPURF_IDX_USP) begin
                    uspQ <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_ISP) begin
                    ispQ <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_SB) begin
                    sbQ <= regWrData[15:0];
                end else if (regAddr == `CPURF_IDX_SP) begin
                    if (flgQ[`CPURF_FLG_U]) begin
                        uspQ <= regWrData[15:0];
                    end else begin
                        ispQ <= regWrData[15:0];
                    end
                end
            end
            // software load of the program counter, else it holds
            if (regWrStb && regAddr == `CPURF_IDX_PC) begin
                pcQ <= regWrData[19:0];
            end
            flgQ <= flgD;
        end
    end

    // read data in the cycle after the strobe only
    always @(posedge clk) begin
        if (rst) begin
            regRdData <= 32'h00000000;
        end else if (!regRdStb) begin
            regRdData <= 32'h00000000;
        end else if (regAddr == `CPURF_IDX_R0) begin
            regRdData <= {16'h0000, r0};
        end else if (regAddr == `CPURF_IDX_R1) begin
            regRdData <= {16'h0000, r1};
        end else if (regAddr == `CPURF_IDX_R2) begin
            regRdData <= {16'h0000, r2};
        end else if (regAddr == `CPURF_IDX_R3) begin
            regRdData <= {16'h0000, r3};
        end else if (regAddr == `CPURF_IDX_A0) begin
            regRdData <= {16'h0000, a0};
        end else if (regAddr == `CPURF_IDX_A1) begin
            regRdData <= {16'h0000, a1};
        end else if (regAddr == `CPURF_IDX_FB) begin
            regRdData <= {16'h0000, fb};
        end else if (regAddr == `CPURF_IDX_R0U) begin
            regRdData <= {24'h000000, r0[15:8]};
        end else if (regAddr == `CPURF_IDX_R0L) begin
            regRdData <= {24'h000000, r0[7:0]};
        end else if (regAddr == `CPURF_IDX_R1U) begin
            regRdData <= {24'h000000, r1[15:8]};
        end else if (regAddr == `CPURF_IDX_R1L) begin
            regRdData <= {24'h000000, r1[7:0]};
        end else if (regAddr == `CPURF_IDX_LDL) begin
            regRdData <= {r2, r0};
        end else if (regAddr == `CPURF_IDX_LDH) begin
            regRdData <= {r3, r1};
        end else if (regAddr == `CPURF_IDX_LAP) begin
            regRdData <= {a1, a0};
        end else if (regAddr == `CPURF_IDX_VTB) begin
            regRdData <= {12'h000, vtbQ};
        end else if (regAddr == `CPURF_IDX_PC) begin
            regRdData <= {12'h000, pcQ};
        end else if (regAddr == `CPURF_IDX_USP) begin
            regRdData <= {16'h0000, uspQ};
        end else if (regAddr == `CPURF_IDX_ISP) begin
            regRdData <= {16'h0000, ispQ};
        end else if (regAddr == `CPURF_IDX_SB) begin
            regRdData <= {16'h0000, sbQ};
        end else if (regAddr == `CPURF_IDX_FLG) begin
            // reserved bits are free to be anything; zero is simplest
            regRdData <= {16'h0000, flgQ};
        end else if (regAddr == `CPURF_IDX_SP) begin
            regRdData <= {16'h0000, sp};
        end else begin
            regRdData <= 32'h00000000;
        end
    end

    // registered status; lags the flag word, stack pointers and program counter by one cycle
    always @(posedge clk) begin
        if (rst) begin
            intEnabled <= 1'b0;
            userStackSel <= 1'b0;
            bankSel <= 1'b0;
            activeStack <= `CPURF_RST16;
            progCounter <= `CPURF_RST20;
        end else begin
            // maskable request passes only above the level
            intEnabled <= intReqValid & flgQ[`CPURF_FLG_I] &
                (intReqLevel > flgQ[`CPURF_IPL_HI:`CPURF_IPL_LO]);
            userStackSel <= flgQ[`CPURF_FLG_U];
            bankSel <= bankB;
            activeStack <= sp;
            progCounter <= pcQ;
        end
    end
endmodule

// ### shared/cpurf_regs.vh
// register indices, flag layout and reset values of the cpu register file
`ifndef CPURF_REGS_VH
`define CPURF_REGS_VH
`define CPURF_ADDR_W 5
`define CPURF_IDX_R0 5'h00
`define CPURF_IDX_R1 5'h01
`define CPURF_IDX_R2 5'h02
`define CPURF_IDX_R3 5'h03
`define CPURF_IDX_A0 5'h04
`define CPURF_IDX_A1 5'h05
`define CPURF_IDX_FB 5'h06
`define CPURF_IDX_R0U 5'h07
`define CPURF_IDX_R0L 5'h08
`define CPURF_IDX_R1U 5'h09
`define CPURF_IDX_R1L 5'h0A
`define CPURF_IDX_LDL 5'h0B
`define CPURF_IDX_LDH 5'h0C
`define CPURF_IDX_LAP 5'h0D
`define CPURF_IDX_VTB 5'h0E
`define CPURF_IDX_PC 5'h0F
`define CPURF_IDX_USP 5'h10
`define CPURF_IDX_ISP 5'h11
`define CPURF_IDX_SB 5'h12
`define CPURF_IDX_FLG 5'h13
`define CPURF_IDX_SP 5'h14
`define CPURF_FLG_C 0
`define CPURF_FLG_D 1
`define CPURF_FLG_Z 2
`define CPURF_FLG_S 3
`define CPURF_FLG_B 4
`define CPURF_FLG_O 5
`define CPURF_FLG_I 6
`define CPURF_FLG_U 7
`define CPURF_FLG_RSV 11
`define CPURF_IPL_LO 12
`define CPURF_IPL_HI 14
`define CPURF_FLG_WMASK 16'h70FF
`define CPURF_RST16 16'h0000
`define CPURF_RST20 20'h00000
`define CPURF_SWI_USER_MAX 6'h1F
`endif

// ### verif/cpurf_core_properties.sv
// port-level assertions and covers for the cpu register file
`timescale 1ns/10ps
`include "cpurf_regs.vh"
module cpurf_chk (
    input wire clk,
    input wire rst,
    input wire [4:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    input wire [31:0] regRdData,
    input wire hwIntAccept,
    input wire swIntExec,
    input wire [5:0] swIntNum,
    input wire [2:0] intReqLevel,
    input wire intReqValid,
    input wire intEnabled,
    input wire userStackSel,
    input wire bankSel,
    input wire [19:0] progCounter
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire flgWr = regWrStb && regAddr == `CPURF_IDX_FLG;
    rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
        else $error("read data not zero outside its slot");
    hw_int_clear_a: assert property (hwIntAccept |-> ##2 !userStackSel && !intEnabled)
        else $error("hardware interrupt left stack select or enable set");
    sw_low_clear_a: assert property (swIntExec && swIntNum <= 6'h1F |-> ##2 !userStackSel)
        else $error("low software vector left stack select set");
    sw_high_keep_a: assert property (swIntExec && swIntNum > 6'h1F && !hwIntAccept && !flgWr
        |-> ##2 $stable(userStackSel)) else $error("high software vector moved stack select");
    int_req_gate_a: assert property (intEnabled |-> $past(intReqValid) && $past(intReqLevel) != 3'h0)
        else $error("request enabled without a request above level zero");
    bank_sel_cause_a: assert property ($changed(bankSel) |-> $past(flgWr, 2))
        else $error("bank select changed without a flag write");
    stack_rise_cause_a: assert property ($rose(userStackSel) |-> $past(flgWr, 2) && $past(regWrData[7], 2))
        else $error("stack select rose without a flag write setting it");
    pc_change_cause_a: assert property ($changed(progCounter) |-> $past(regWrStb, 2)
        && $past(regAddr, 2) == `CPURF_IDX_PC) else $error("program counter moved without a write");
    cover property (hwIntAccept && flgWr);
    cover property (swIntExec && swIntNum > 6'h1F);
    cover property ($rose(bankSel));
endmodule
bind cpurf_core cpurf_chk cpurf_chk_i (.*);

// ### verif/cpurf_core_tb.sv
// self-checking bench for the cpu register file
`timescale 1ns/10ps
`include "cpurf_regs.vh"
module cpurf_core_tb;
    logic clk, rst, regWrStb, regRdStb, aluFlagStb, aluCarry, aluZero, aluSign, aluOverflow;
    logic hwIntAccept, swIntExec, intReqValid, intEnabled, userStackSel, bankSel, rdPrev;
    logic [4:0] regAddr;
    logic [31:0] regWrData, regRdData, v;
    logic [5:0] swIntNum;
    logic [2:0] intReqLevel;
    logic [15:0] activeStack, fl;
    logic [19:0] progCounter;
    logic [31:0] expQ[$];
    logic [15:0] bk[0:1][0:6];
    logic [5:0] nums[0:3] = '{6'h1F, 6'h20, 6'h00, 6'h3F};
    int n_mismatch, cmp_count, i;
    localparam logic [4:0] FIDX = `CPURF_IDX_FLG;
    cpurf_core cpurf_core_i (.*);
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task end_sim;
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one bus cycle; every pulse input is driven each call so none lingers
    task cyc(input logic w, r, input logic [4:0] a, input logic [31:0] d, input logic [2:0] f);
        regWrStb <= w;
        regRdStb <= r;
        regAddr <= a;
        regWrData <= d;
        {swIntExec, hwIntAccept, aluFlagStb} <= f;
        @(posedge clk);
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        expQ.push_back(e);
        cyc(0, 1, a, 32'h0, 3'h0);
    endtask
    task wfl(input logic [15:0] d);
        fl = d & `CPURF_FLG_WMASK;
        cyc(1, 0, FIDX, {16'h0, d}, 3'h0);
    endtask
    always @(posedge clk) begin
        if (rdPrev) check("regRdData", regRdData, expQ.pop_front());
        rdPrev <= regRdStb;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        {regWrStb, regRdStb, aluFlagStb, aluCarry, aluZero, aluSign, aluOverflow} = '0;
        {hwIntAccept, swIntExec, intReqValid, regAddr, regWrData, swIntNum, intReqLevel} = '0;
        rdPrev = 0;
        rst = 1;
        v = $urandom(91862);
        repeat (8) @(posedge clk);
        rst <= 0;
        rd(FIDX, 32'h0);
        for (i = 0; i < 14; i++) begin
            if (i == 7) wfl(16'h0010);
            v = $urandom;
            bk[i / 7][i % 7] = v[15:0];
            cyc(1, 0, 5'(i % 7), {16'h0, v[15:0]}, 3'h0);
            rd(5'(i % 7), {16'h0, v[15:0]});
        end
        wfl(16'h0000);
        for (i = 0; i < 7; i++) rd(5'(i), {16'h0, bk[0][i]});
        cyc(1, 0, `CPURF_IDX_R0U, 32'h5A, 3'h0);
        cyc(1, 0, `CPURF_IDX_R1L, 32'hA5, 3'h0);
        rd(`CPURF_IDX_R0, {16'h0, 8'h5A, bk[0][0][7:0]});
        rd(`CPURF_IDX_R0L, {24'h0, bk[0][0][7:0]});
        rd(`CPURF_IDX_R1U, {24'h0, bk[0][1][15:8]});
        rd(`CPURF_IDX_LDH, {bk[0][3], bk[0][1][15:8], 8'hA5});
        rd(`CPURF_IDX_LAP, {bk[0][5], bk[0][4]});
        v = $urandom;
        cyc(1, 0, `CPURF_IDX_LDL, v, 3'h0);
        rd(`CPURF_IDX_R2, {16'h0, v[31:16]});
        cyc(1, 0, `CPURF_IDX_PC, {12'h0, v[19:0]}, 3'h0);
        rd(`CPURF_IDX_PC, {12'h0, v[19:0]});
        #1 check("progCounter", {12'h0, progCounter}, {12'h0, v[19:0]});
        cyc(1, 0, `CPURF_IDX_VTB, {12'h0, v[31:12]}, 3'h0);
        rd(`CPURF_IDX_VTB, {12'h0, v[31:12]});
        cyc(1, 0, `CPURF_IDX_USP, {16'h0, v[15:0]}, 3'h0);
        cyc(1, 0, `CPURF_IDX_ISP, {16'h0, v[31:16]}, 3'h0);
        rd(`CPURF_IDX_SP, {16'h0, v[31:16]});
        wfl(16'h0080);
        rd(`CPURF_IDX_SP, {16'h0, v[15:0]});
        #1 check("activeStack", {16'h0, activeStack}, {16'h0, v[15:0]});
        wfl(16'h70FD);
        rd(FIDX, {16'h0, fl});
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            {aluCarry, aluZero, aluSign, aluOverflow} <= v[3:0];
            {fl[0], fl[2], fl[3], fl[5]} = v[3:0];
            cyc(0, 0, 5'h0, 32'h0, 3'b001);
            rd(FIDX, {16'h0, fl});
        end
        wfl(16'h3040);
        intReqValid <= 1;
        for (i = 0; i < 8; i++) begin
            intReqLevel <= 3'(i);
            cyc(0, 0, 5'h0, 32'h0, 3'h0);
            #1 check("intEnabled", {31'h0, intEnabled}, {31'h0, i > 3});
        end
        wfl(16'h3000);
        cyc(0, 0, 5'h0, 32'h0, 3'h0);
        #1 check("intEnabled", {31'h0, intEnabled}, 32'h0);
        wfl(16'h00C0);
        cyc(1, 0, FIDX, 32'h00D0, 3'b010);
        rd(FIDX, 32'h0010);
        #1 check("userStackSel", {31'h0, userStackSel}, 32'h0);
        for (i = 0; i < 4; i++) begin
            wfl(16'h00C0);
            swIntNum <= nums[i];
            cyc(0, 0, 5'h0, 32'h0, 3'b100);
            rd(FIDX, {24'h0, nums[i] > 6'h1F, 7'h0});
        end
        cyc(1, 0, 5'h1F, 32'hFFFFFFFF, 3'h0);
        rd(5'h1F, 32'h0);
        cyc(0, 0, 5'h0, 32'h0, 3'h0);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(`CPURF_IDX_R0, 32'h0);
        cyc(0, 0, 5'h0, 32'h0, 3'h0);
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule
